// *** reset_hold_timer.sv ***
// counts the minimum width of the system reset pulse
`timescale 1ns/1ns
module reset_hold_timer #(
  parameter int CYCLES = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count_q;

  // power-up counts as a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= LOAD;
    end else if (restart) begin
      count_q <= LOAD;
    end else if (count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  assign busy = (count_q != '0);
endmodule

// *** reset_source_controller.sv ***
// reset source controller: cause register, reset sequence, apb slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module reset_source_controller (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources
  input wire logic ext_reset_n,
  input wire logic supply_fail,
  input wire logic wdt_timeout,
  // ram validity inputs
  input wire logic lin_download_done,
  input wire logic lv_flag_enable,
  input wire logic low_voltage_flag,
  // boot kernel handshake
  input wire logic kernel_done,
  // reset outputs
  output logic sys_reset_n_q,
  output logic wdt_reset_n_q,
  // boot and memory map
  output logic kernel_run_q,
  output logic vector_jump_q,
  output logic [31:0] vector_addr_q,
  output logic memory_remap_control_q,
  output logic [31:0] boot_map_q,
  output logic ram_valid_q,
  // interrupt
  output logic irq_q
);

  logic [1:0] pin_sync;
  logic por_req;
  logic ext_req;
  logic wdt_req;
  logic sw_req;
  logic any_req;
  logic wr_en;
  logic wr_status;
  logic wr_clear;
  logic wr_remap;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [rsc_pkg::CAUSE_W-1:0] new_cause;
  logic [rsc_pkg::CAUSE_W-1:0] clr_mask;
  logic [rsc_pkg::CAUSE_W-1:0] cause_q;
  logic [rsc_pkg::CAUSE_W-1:0] seq_cause_q;
  logic [rsc_pkg::CAUSE_W-1:0] irq_status_q;
  logic [rsc_pkg::CAUSE_W-1:0] irq_mask_q;
  logic seq_por_q;
  logic seq_por_d;
  logic lin_dl_q;
  logic hold_busy;
  logic leave_hold;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  rsc_pkg::seq_state_e state_q;
  rsc_pkg::seq_state_e state_d;

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == rsc_pkg::ADDR_REMAP) || (a == rsc_pkg::ADDR_CAUSE_STATUS) ||
                (a == rsc_pkg::ADDR_CAUSE_CLEAR) || (a == rsc_pkg::ADDR_IRQ_STATUS) ||
                (a == rsc_pkg::ADDR_IRQ_MASK) || (a == rsc_pkg::ADDR_RESET_STATE);
  endfunction

  function automatic logic [31:0] pad_cause(input logic [rsc_pkg::CAUSE_W-1:0] v);
    pad_cause = {{(32 - rsc_pkg::CAUSE_W){1'b0}}, v};
  endfunction

  // pins cross into the pclk domain
  sync2 #(
    .WIDTH(2),
    .RST_VAL(2'h1)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({supply_fail, ext_reset_n}),
    .q(pin_sync)
  );

  // apb write decode
  assign wr_en = psel && penable && pwrite && pready_q && !pslverr_q;
  assign wr_status = wr_en && (paddr == rsc_pkg::ADDR_CAUSE_STATUS);
  assign wr_clear = wr_en && (paddr == rsc_pkg::ADDR_CAUSE_CLEAR);
  assign wr_remap = wr_en && (paddr == rsc_pkg::ADDR_REMAP);
  assign wr_irq_status = wr_en && (paddr == rsc_pkg::ADDR_IRQ_STATUS);
  assign wr_irq_mask = wr_en && (paddr == rsc_pkg::ADDR_IRQ_MASK);

  assign por_req = pin_sync[1];
  assign ext_req = !pin_sync[0];
  assign wdt_req = wdt_timeout;
  // clear write that spares bit 2 retriggers
  assign sw_req = (wr_status && pwdata[rsc_pkg::CAUSE_SW]) ||
                  (wr_clear && cause_q[rsc_pkg::CAUSE_SW] && !pwdata[rsc_pkg::CAUSE_SW]);
  assign any_req = por_req || ext_req || wdt_req || sw_req;

  always_comb begin
    new_cause = '0;
    new_cause[rsc_pkg::CAUSE_POR] = por_req;
    new_cause[rsc_pkg::CAUSE_WDT] = wdt_req;
    new_cause[rsc_pkg::CAUSE_SW] = sw_req;
    new_cause[rsc_pkg::CAUSE_EXT] = ext_req;
  end

  assign clr_mask = wr_clear ? pwdata[rsc_pkg::CAUSE_W-1:0] : '0;

  // only power-up initialises the cause register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= rsc_pkg::CAUSE_AFTER_POR;
    end else begin
      cause_q <= (cause_q & ~clr_mask) | new_cause;
    end
  end

  // reset sequence
  reset_hold_timer #(
    .CYCLES(rsc_pkg::RESET_HOLD_CYCLES)
  ) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .restart(any_req),
    .busy(hold_busy)
  );

  assign leave_hold = (state_q == rsc_pkg::SEQ_HOLD) && !hold_busy && !any_req;

  always_comb begin
    state_d = state_q;
    if (any_req) begin
      state_d = rsc_pkg::SEQ_HOLD;
    end else begin
      case (state_q)
        rsc_pkg::SEQ_HOLD: begin
          if (leave_hold) begin
            state_d = rsc_pkg::SEQ_KERNEL;
          end
        end
        // kernel routine precedes the vector jump
        rsc_pkg::SEQ_KERNEL: begin
          if (kernel_done) begin
            state_d = rsc_pkg::SEQ_JUMP;
          end
        end
        rsc_pkg::SEQ_JUMP: begin
          state_d = rsc_pkg::SEQ_RUN;
        end
        rsc_pkg::SEQ_RUN: begin
          state_d = rsc_pkg::SEQ_RUN;
        end
        default: begin
          state_d = rsc_pkg::SEQ_HOLD;
        end
      endcase
    end
  end

  // power-on kind is remembered through the hold phase, then follows por_req again
  assign seq_por_d = (state_q == rsc_pkg::SEQ_HOLD) ? (seq_por_q || por_req) : por_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rsc_pkg::SEQ_HOLD;
      seq_por_q <= 1'b1;
      seq_cause_q <= rsc_pkg::CAUSE_AFTER_POR;
    end else begin
      state_q <= state_d;
      seq_por_q <= seq_por_d;
      if (any_req) begin
        seq_cause_q <= ((state_q == rsc_pkg::SEQ_HOLD) ? seq_cause_q : '0) | new_cause;
      end
    end
  end

  // one system reset for pins, kernel, registers, hv and peripherals
  // watchdog reset only for power-on sequences
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_n_q <= 1'b0;
      wdt_reset_n_q <= 1'b0;
    end else begin
      sys_reset_n_q <= (state_d != rsc_pkg::SEQ_HOLD);
      wdt_reset_n_q <= !((state_d == rsc_pkg::SEQ_HOLD) && seq_por_d);
    end
  end

  // kernel run, then one-cycle jump to the reset vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kernel_run_q <= 1'b0;
      vector_jump_q <= 1'b0;
      vector_addr_q <= rsc_pkg::RESET_VECTOR;
    end else begin
      kernel_run_q <= (state_d == rsc_pkg::SEQ_KERNEL);
      vector_jump_q <= (state_d == rsc_pkg::SEQ_JUMP);
      vector_addr_q <= rsc_pkg::RESET_VECTOR;
    end
  end

  // lin download marker survives the system reset it precedes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_dl_q <= 1'b0;
    end else if (lin_download_done) begin
      lin_dl_q <= 1'b1;
    end else if (leave_hold) begin
      lin_dl_q <= 1'b0;
    end
  end

  // power-on keeps ram only with the flag enabled and set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_valid_q <= 1'b0;
    end else if (leave_hold) begin
      ram_valid_q <= !lin_dl_q && (!seq_por_q || (lv_flag_enable && low_voltage_flag));
    end
  end

  // remap bit cleared by any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_remap_control_q <= 1'b0;
    end else if (state_q == rsc_pkg::SEQ_HOLD) begin
      memory_remap_control_q <= 1'b0;
    end else if (wr_remap) begin
      memory_remap_control_q <= pwdata[rsc_pkg::REMAP_BIT];
    end
  end

  // program memory aliased at zero unless remapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_map_q <= rsc_pkg::FLASH_PHYS_BASE;
    end else begin
      boot_map_q <= memory_remap_control_q ? rsc_pkg::SRAM_PHYS_BASE : rsc_pkg::FLASH_PHYS_BASE;
    end
  end

  // interrupt status: set on each completed reset, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else if (state_q == rsc_pkg::SEQ_HOLD) begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_irq_status ? pwdata[rsc_pkg::CAUSE_W-1:0] : '0)) |
                      ((state_q == rsc_pkg::SEQ_JUMP) ? seq_cause_q : '0);
      if (wr_irq_mask) begin
        irq_mask_q <= pwdata[rsc_pkg::CAUSE_W-1:0];
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // apb read data and error are taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (psel && !penable) begin
        pslverr_q <= !is_mapped(paddr);
        prdata_q <= '0;
        case (paddr)
          rsc_pkg::ADDR_CAUSE_STATUS: prdata_q <= pad_cause(cause_q);
          rsc_pkg::ADDR_REMAP: prdata_q <= {31'h0, memory_remap_control_q};
          rsc_pkg::ADDR_IRQ_STATUS: prdata_q <= pad_cause(irq_status_q);
          rsc_pkg::ADDR_IRQ_MASK: prdata_q <= pad_cause(irq_mask_q);
          rsc_pkg::ADDR_RESET_STATE: begin
            prdata_q[rsc_pkg::STATE_RAM_VALID] <= ram_valid_q;
            prdata_q[rsc_pkg::STATE_KERNEL] <= kernel_run_q;
            prdata_q[rsc_pkg::STATE_LIN_DL] <= lin_dl_q;
          end
          default: prdata_q <= '0;
        endcase
      end else if (!psel) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sw_write_reset: assert property (wr_status && pwdata[rsc_pkg::CAUSE_SW] |=> !sys_reset_n_q && cause_q[2])
    else $error("software write did not start a reset");
  a_clear_retrigger: assert property (wr_clear && cause_q[2] && !pwdata[2] |=> !sys_reset_n_q)
    else $error("clear write sparing bit 2 did not retrigger");
  a_ext_sets_bit: assert property (ext_req |=> cause_q[3] && !sys_reset_n_q)
    else $error("pin reset not recorded");
  a_wdt_sets_bit: assert property (wdt_timeout |=> cause_q[1] && !sys_reset_n_q)
    else $error("watchdog reset not recorded");
  a_por_sets_bit: assert property (por_req |=> cause_q[0] && !wdt_reset_n_q)
    else $error("power-on reset not recorded");
  a_clear_one_bit: assert property (wr_clear && pwdata[1] && !wdt_timeout |=> !cause_q[1])
    else $error("clear write left bit set");
  a_zero_keeps: assert property (wr_clear && !pwdata[0] && cause_q[0] |=> cause_q[0])
    else $error("zero write cleared a status bit");
  a_upper_zero: assert property (psel && !penable && paddr == rsc_pkg::ADDR_CAUSE_STATUS |=> ~|prdata_q[7:4])
    else $error("unused status bits not zero");
  a_status_kept: assert property (state_q == rsc_pkg::SEQ_HOLD && !wr_clear |=>
    (cause_q & $past(cause_q)) == $past(cause_q))
    else $error("reset cleared the cause register");
  a_wdt_untouched: assert property (state_q == rsc_pkg::SEQ_RUN && wdt_req && !por_req |=> wdt_reset_n_q)
    else $error("watchdog timer reset by non power-on reset");
  a_hold_length: assert property ($fell(sys_reset_n_q) |-> !sys_reset_n_q [*8])
    else $error("system reset pulse too short");
  a_remap_cleared: assert property (state_q == rsc_pkg::SEQ_HOLD |=> !memory_remap_control_q)
    else $error("remap bit survived reset");
  a_kernel_first: assert property ($rose(vector_jump_q) |-> $past(kernel_run_q) && vector_addr_q == 32'h0)
    else $error("vector jump without kernel run");
  a_ram_lin_bad: assert property (leave_hold && lin_dl_q |=> !ram_valid_q)
    else $error("ram valid after lin download");
  a_ram_por_flag: assert property (leave_hold && seq_por_q && !lin_dl_q |=>
    ram_valid_q == $past(lv_flag_enable && low_voltage_flag))
    else $error("ram validity wrong after power-on");
  a_boot_map: assert property (!memory_remap_control_q |=> boot_map_q == rsc_pkg::FLASH_PHYS_BASE)
    else $error("program memory not mapped at zero");
  a_any_source: assert property (any_req |=> !sys_reset_n_q)
    else $error("reset source did not reset system");

endmodule

// *** rsc_pkg.sv ***
// constants, register map and state type of the reset source controller
package rsc_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_REMAP = 32'hffff0220;
  localparam logic [31:0] ADDR_CAUSE_STATUS = 32'hffff0230;
  localparam logic [31:0] ADDR_CAUSE_CLEAR = 32'hffff0234;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hffff0238;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hffff023c;
  localparam logic [31:0] ADDR_RESET_STATE = 32'hffff0240;

  // reset cause bit positions
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_SW = 2;
  localparam int CAUSE_EXT = 3;
  localparam int CAUSE_W = 4;
  localparam int STATUS_W = 8;
  localparam logic [3:0] CAUSE_AFTER_POR = 4'h1;

  // remap and reset state fields
  localparam int REMAP_BIT = 0;
  localparam int STATE_RAM_VALID = 0;
  localparam int STATE_KERNEL = 1;
  localparam int STATE_LIN_DL = 2;

  // memory map
  localparam logic [31:0] RESET_VECTOR = 32'h00000000;
  localparam logic [31:0] FLASH_PHYS_BASE = 32'h00080000;
  localparam logic [31:0] SRAM_PHYS_BASE = 32'h00040000;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RESET_HOLD_NS = 500;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_KERNEL,
    SEQ_JUMP,
    SEQ_RUN
  } seq_state_e;

endpackage

// *** sync2.sv ***
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// *** test_reset_source_controller.sv ***
// self-checking testbench of the reset source controller
`timescale 1ns/1ns
module test_reset_source_controller;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, vector_addr_q, boot_map_q;
  logic ext_reset_n, supply_fail, wdt_timeout, lin_download_done;
  logic lv_flag_enable, low_voltage_flag, kernel_done;
  logic sys_reset_n_q, wdt_reset_n_q, kernel_run_q, vector_jump_q;
  logic memory_remap_control_q, ram_valid_q, irq_q;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic wl;
  logic err;
  logic [31:0] rdat;

  reset_source_controller u_reset_source_controller (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ext_reset_n, .supply_fail, .wdt_timeout, .lin_download_done, .lv_flag_enable,
    .low_voltage_flag, .kernel_done, .sys_reset_n_q, .wdt_reset_n_q, .kernel_run_q,
    .vector_jump_q, .vector_addr_q, .memory_remap_control_q, .boot_map_q, .ram_valid_q, .irq_q
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk1("pready", 1'b1, pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rdat, err);
    chk1("write pslverr", 1'b0, err);
  endtask

  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rdat, err);
    chk(n, e, rdat);
    chk1("read pslverr", 1'b0, err);
  endtask

  // follows one reset sequence and plays the boot kernel
  task automatic run_seq(output logic wlow);
    int n;
    wlow = 1'b0;
    n = 0;
    while (sys_reset_n_q !== 1'b0 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk1("sys reset entry", 1'b0, sys_reset_n_q);
    n = 0;
    while (kernel_run_q !== 1'b1 && n < 200) begin
      if (wdt_reset_n_q === 1'b0) wlow = 1'b1;
      @(negedge pclk);
      n++;
    end
    chk1("kernel run", 1'b1, kernel_run_q);
    chk1("sys reset release", 1'b1, sys_reset_n_q);
    chk1("no early jump", 1'b0, vector_jump_q);
    @(posedge pclk) kernel_done <= 1'b1;
    @(posedge pclk) kernel_done <= 1'b0;
    n = 0;
    while (vector_jump_q !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    chk1("vector jump", 1'b1, vector_jump_q);
    chk("vector address", 32'h0, vector_addr_q);
    repeat (2) @(negedge pclk);
  endtask

  task automatic done_test(input string s);
    $display("test %s finished, mismatches so far %0d", s, miscompares);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ext_reset_n = 1'b1;
    supply_fail = 1'b0;
    wdt_timeout = 1'b0;
    lin_download_done = 1'b0;
    lv_flag_enable = 1'b0;
    low_voltage_flag = 1'b0;
    kernel_done = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run_seq(wl);
    chk1("por wdt reset", 1'b1, wl);
    rd("status after por", rsc_pkg::ADDR_CAUSE_STATUS, 32'h01);
    chk("boot map", 32'h00080000, boot_map_q);
    chk1("ram invalid no flag", 1'b0, ram_valid_q);
    rd("clear reads zero", rsc_pkg::ADDR_CAUSE_CLEAR, 32'h0);
    done_test("power up");

    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h0);
    rd("zero clear keeps", rsc_pkg::ADDR_CAUSE_STATUS, 32'h01);
    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h01);
    rd("bit cleared", rsc_pkg::ADDR_CAUSE_STATUS, 32'h0);
    wr(rsc_pkg::ADDR_CAUSE_STATUS, 32'hf0);
    rd("unused bits zero", rsc_pkg::ADDR_CAUSE_STATUS, 32'h0);
    xfer(1'b0, 32'hffff0300, 32'h0, rdat, err);
    chk1("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0, rdat);
    done_test("clear");

    lv_flag_enable <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    run_seq(wl);
    chk1("wdt keeps watchdog", 1'b0, wl);
    rd("watchdog cause", rsc_pkg::ADDR_CAUSE_STATUS, 32'h02);
    chk1("ram valid after wdt", 1'b1, ram_valid_q);
    done_test("watchdog");

    wr(rsc_pkg::ADDR_REMAP, 32'h1);
    rd("remap set", rsc_pkg::ADDR_REMAP, 32'h1);
    chk1("remap output set", 1'b1, memory_remap_control_q);
    repeat (2) @(negedge pclk);
    chk("sram at zero", 32'h00040000, boot_map_q);
    @(posedge pclk) ext_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n <= 1'b1;
    run_seq(wl);
    chk1("pin keeps watchdog", 1'b0, wl);
    rd("pin cause", rsc_pkg::ADDR_CAUSE_STATUS, 32'h0a);
    rd("remap cleared", rsc_pkg::ADDR_REMAP, 32'h0);
    chk1("remap output cleared", 1'b0, memory_remap_control_q);
    chk("flash at zero", 32'h00080000, boot_map_q);
    done_test("pin and remap");

    rd("irq status", rsc_pkg::ADDR_IRQ_STATUS, 32'h08);
    rd("irq mask reset", rsc_pkg::ADDR_IRQ_MASK, 32'h0);
    chk1("irq masked", 1'b0, irq_q);
    wr(rsc_pkg::ADDR_IRQ_MASK, 32'h08);
    repeat (2) @(negedge pclk);
    chk1("irq raised", 1'b1, irq_q);
    wr(rsc_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(negedge pclk);
    chk1("irq masked off", 1'b0, irq_q);
    wr(rsc_pkg::ADDR_IRQ_MASK, 32'h08);
    wr(rsc_pkg::ADDR_IRQ_STATUS, 32'h08);
    repeat (2) @(negedge pclk);
    chk1("irq cleared", 1'b0, irq_q);
    rd("irq status cleared", rsc_pkg::ADDR_IRQ_STATUS, 32'h0);
    done_test("interrupt");

    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h0f);
    wr(rsc_pkg::ADDR_CAUSE_STATUS, 32'h04);
    run_seq(wl);
    chk1("sw keeps watchdog", 1'b0, wl);
    rd("sw cause", rsc_pkg::ADDR_CAUSE_STATUS, 32'h04);
    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h08);
    run_seq(wl);
    rd("sw again", rsc_pkg::ADDR_CAUSE_STATUS, 32'h04);
    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h04);
    repeat (20) begin
      @(negedge pclk);
      chk1("no further reset", 1'b1, sys_reset_n_q);
    end
    rd("sw cleared", rsc_pkg::ADDR_CAUSE_STATUS, 32'h0);
    done_test("software");

    @(posedge pclk) lin_download_done <= 1'b1;
    @(posedge pclk) lin_download_done <= 1'b0;
    rd("state lin marked", rsc_pkg::ADDR_RESET_STATE, 32'h05);
    wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    run_seq(wl);
    chk1("ram invalid after lin", 1'b0, ram_valid_q);
    rd("state after lin", rsc_pkg::ADDR_RESET_STATE, 32'h0);
    done_test("lin download");

    wr(rsc_pkg::ADDR_CAUSE_CLEAR, 32'h0f);
    low_voltage_flag <= 1'b1;
    @(posedge pclk) supply_fail <= 1'b1;
    repeat (3) @(posedge pclk);
    supply_fail <= 1'b0;
    run_seq(wl);
    chk1("supply wdt reset", 1'b1, wl);
    rd("supply cause", rsc_pkg::ADDR_CAUSE_STATUS, 32'h01);
    chk1("ram valid flag set", 1'b1, ram_valid_q);
    low_voltage_flag <= 1'b0;
    @(posedge pclk) supply_fail <= 1'b1;
    repeat (3) @(posedge pclk);
    supply_fail <= 1'b0;
    run_seq(wl);
    chk1("ram invalid flag low", 1'b0, ram_valid_q);
    done_test("supply");
    print_verdict();
  end
endmodule
